// ==== hw/ccsc_cpu_clock_switchover_control.sv ====
// Purpose: CPU clock and main system clock selection with switchover latency
// Assumes: cpu_clk_tick pulses once per current CPU clock, main_clk_tick once per main clock
// Notes: Latencies are counted by accumulation, so no divider is needed
// Contract
// - Divider bits 2:0, CPU source select bit 4
// - Old CPU clock kept for latency after write
// - Read-only bit 5 shows CPU clock source
// - Divider change 16>>div clocks; sub-to-main 2
// - Main-to-sub ratio scaled by divider, rounded up
// - Divider change with sub-to-main in one write
// - Main mode bit 0 selects main clock source
// - Old main clock kept for latency after write
// - Main mode bit 1 shows main clock source
// - Main switch takes 1 + 2*old/new, truncated
// - High-speed source enable writable once per reset
// - High-speed stop at bit 7 of main_osc_control
`timescale 1ns/10ps
`default_nettype none
module ccsc_cpu_clock_switchover_control
  import ccsc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic cpu_clk_tick,
  input wire logic main_clk_tick,
  output logic [2:0] main_divider_out,
  output logic cpu_on_subsystem,
  output logic main_on_high_speed,
  output logic internal_osc_stop_out,
  output logic high_speed_clock_stop_out,
  output logic subsystem_osc_enable_out
);

  // Bus slave state
  logic aw_held_reg, aw_held_next;
  logic [7:0] aw_addr_reg, aw_addr_next;
  logic w_held_reg, w_held_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic do_write;
  logic [31:0] rd_value;
  logic rd_hit;

  // Software-written registers
  logic [2:0] div_sel_reg, div_sel_next;
  logic cpu_sel_reg, cpu_sel_next;
  logic main_sel_reg, main_sel_next;
  logic hs_en_reg, hs_en_next;
  logic hs_en_locked_reg, hs_en_locked_next;
  logic hs_stop_reg, hs_stop_next;
  logic int_stop_reg, int_stop_next;
  logic sub_en_reg, sub_en_next;
  logic [15:0] int_freq_reg, int_freq_next;
  logic [15:0] hs_freq_reg, hs_freq_next;
  logic [15:0] sub_freq_reg, sub_freq_next;

  // Applied clock state and latency accumulators
  logic [2:0] div_act_reg, div_act_next;
  logic cpu_act_reg, cpu_act_next;
  logic main_act_reg, main_act_next;
  logic [31:0] pcc_acc_reg, pcc_acc_next;
  logic [31:0] mcm_acc_reg, mcm_acc_next;
  logic pcc_wr, mcm_wr, pcc_busy, mcm_busy;
  logic [31:0] pcc_step, pcc_target, pcc_sum;
  logic [31:0] mcm_sum, mcm_limit;
  logic [15:0] main_freq_old, main_freq_new;

  // Oscillator outputs
  logic int_gate_reg, int_gate_next;
  logic hs_gate_reg, hs_gate_next;
  logic sub_gate_reg, sub_gate_next;

  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  assign pcc_wr = do_write && aw_addr_reg == CCSC_OFS_PROC_CLK && w_strb_reg[0];
  assign mcm_wr = do_write && aw_addr_reg == CCSC_OFS_MAIN_MODE && w_strb_reg[0];

  // Byte-lane merge for the frequency registers
  function automatic logic [31:0] ccsc_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return res;
  endfunction

  // Read decode; status bits come from the applied state
  always_comb
  begin
    rd_value = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      CCSC_OFS_PROC_CLK:
      begin
        rd_value[CCSC_DIV_LSB +: 3] = div_sel_reg;
        rd_value[CCSC_CPU_SEL_BIT] = cpu_sel_reg;
        rd_value[CCSC_CPU_STAT_BIT] = cpu_act_reg;
      end
      CCSC_OFS_MAIN_MODE:
      begin
        rd_value[CCSC_MAIN_SEL_BIT] = main_sel_reg;
        rd_value[CCSC_MAIN_STAT_BIT] = main_act_reg;
        rd_value[CCSC_HS_EN_BIT] = hs_en_reg;
      end
      CCSC_OFS_MAIN_OSC: rd_value[CCSC_HS_STOP_BIT] = hs_stop_reg;
      CCSC_OFS_OSC_CTRL:
      begin
        rd_value[CCSC_INT_STOP_BIT] = int_stop_reg;
        rd_value[CCSC_SUB_EN_BIT] = sub_en_reg;
      end
      CCSC_OFS_FREQ_MAIN: rd_value = {hs_freq_reg, int_freq_reg};
      CCSC_OFS_FREQ_SUB: rd_value[15:0] = sub_freq_reg;
      CCSC_OFS_BUSY:
      begin
        rd_value[CCSC_PCC_BUSY_BIT] = pcc_busy;
        rd_value[CCSC_MCM_BUSY_BIT] = mcm_busy;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // Bus handshakes: one write and one read in flight, read answer one cycle later, write answer two
  always_comb
  begin
    aw_held_next = aw_held_reg;
    aw_addr_next = aw_addr_reg;
    w_held_next = w_held_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (do_write)
    begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = (aw_addr_reg <= CCSC_OFS_FREQ_SUB && aw_addr_reg[1:0] == 2'h0) ? CCSC_RESP_OKAY
                                                                                 : CCSC_RESP_SLVERR;
    end
    else if (bvalid_reg && s_axi_bready)
      bvalid_next = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_next = 1'b1;
      rdata_next = rd_value;
      rresp_next = rd_hit ? CCSC_RESP_OKAY : CCSC_RESP_SLVERR;
    end
    else if (rvalid_reg && s_axi_rready)
      rvalid_next = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= CCSC_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= CCSC_RESP_OKAY;
    end
    else
    begin
      aw_held_reg <= aw_held_next;
      aw_addr_reg <= aw_addr_next;
      w_held_reg <= w_held_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // Register writes; a divider and source change in one write are both kept
  always_comb
  begin
    logic [31:0] fm;
    logic [31:0] fs;
    fm = ccsc_merge({hs_freq_reg, int_freq_reg}, w_data_reg, w_strb_reg);
    fs = ccsc_merge({16'h0000, sub_freq_reg}, w_data_reg, w_strb_reg);
    div_sel_next = div_sel_reg;
    cpu_sel_next = cpu_sel_reg;
    main_sel_next = main_sel_reg;
    hs_en_next = hs_en_reg;
    hs_en_locked_next = hs_en_locked_reg;
    hs_stop_next = hs_stop_reg;
    int_stop_next = int_stop_reg;
    sub_en_next = sub_en_reg;
    int_freq_next = int_freq_reg;
    hs_freq_next = hs_freq_reg;
    sub_freq_next = sub_freq_reg;
    if (pcc_wr)
    begin
      div_sel_next = w_data_reg[CCSC_DIV_LSB +: 3];
      cpu_sel_next = w_data_reg[CCSC_CPU_SEL_BIT];
    end
    if (mcm_wr)
    begin
      main_sel_next = w_data_reg[CCSC_MAIN_SEL_BIT];
      hs_en_locked_next = 1'b1;
      if (!hs_en_locked_reg)
        hs_en_next = w_data_reg[CCSC_HS_EN_BIT];
    end
    if (do_write && w_strb_reg[0])
    begin
      if (aw_addr_reg == CCSC_OFS_MAIN_OSC)
        hs_stop_next = w_data_reg[CCSC_HS_STOP_BIT];
      if (aw_addr_reg == CCSC_OFS_OSC_CTRL)
      begin
        int_stop_next = w_data_reg[CCSC_INT_STOP_BIT];
        sub_en_next = w_data_reg[CCSC_SUB_EN_BIT];
      end
    end
    if (do_write && aw_addr_reg == CCSC_OFS_FREQ_MAIN)
    begin
      int_freq_next = fm[15:0];
      hs_freq_next = fm[31:16];
    end
    if (do_write && aw_addr_reg == CCSC_OFS_FREQ_SUB)
      sub_freq_next = fs[15:0];
  end

  // Latency terms: old main frequency feeds both counters
  assign main_freq_old = main_act_reg ? hs_freq_reg : int_freq_reg;
  assign main_freq_new = main_act_reg ? int_freq_reg : hs_freq_reg;
  assign pcc_busy = (div_sel_reg != div_act_reg) || (cpu_sel_reg != cpu_act_reg);
  assign mcm_busy = main_sel_reg != main_act_reg;
  assign pcc_sum = pcc_acc_reg + pcc_step;
  assign mcm_sum = mcm_acc_reg + {16'h0000, main_freq_new};
  assign mcm_limit = {15'h0000, main_freq_old, 1'b0};

  // Pick step and target so that done means acc reaches target
  always_comb
  begin
    pcc_step = 32'h0000_0001;
    pcc_target = CCSC_DIV_CHANGE_BASE >> div_act_reg;
    if (cpu_act_reg && !cpu_sel_reg)
      pcc_target = CCSC_SUB_TO_MAIN_CNT;
    else if (!cpu_act_reg && cpu_sel_reg)
    begin
      // Step scaled by 8 and target by 16 so the divider shift stays exact
      // A zero frequency falls back to one unit so the wait still ends
      pcc_step = (sub_freq_reg == 16'h0000) ? 32'h0000_0008 : {13'h0000, sub_freq_reg, 3'h0};
      pcc_target = (main_freq_old * {16'h0000, CCSC_HZ_PER_KHZ} << CCSC_SUB_SCALE_SHIFT) >> div_act_reg;
    end
  end

  // Apply the new selection only after the latency expires, except a divider change while on subsystem clock
  always_comb
  begin
    div_act_next = div_act_reg;
    cpu_act_next = cpu_act_reg;
    main_act_next = main_act_reg;
    pcc_acc_next = pcc_acc_reg;
    mcm_acc_next = mcm_acc_reg;
    if (pcc_wr)
      pcc_acc_next = 32'h0000_0000; // A rewrite restarts the wait
    else if (pcc_busy && cpu_act_reg && cpu_sel_reg)
      div_act_next = div_sel_reg; // Divider is unused while on subsystem clock
    else if (pcc_busy && cpu_clk_tick)
    begin
      pcc_acc_next = pcc_sum;
      if (pcc_sum >= pcc_target)
      begin
        div_act_next = div_sel_reg;
        cpu_act_next = cpu_sel_reg;
        pcc_acc_next = 32'h0000_0000;
      end
    end
    if (mcm_wr)
      mcm_acc_next = 32'h0000_0000;
    else if (mcm_busy && main_clk_tick)
    begin
      mcm_acc_next = mcm_sum;
      if (mcm_sum > mcm_limit || main_freq_new == 16'h0000)
      begin
        main_act_next = main_sel_reg;
        mcm_acc_next = 32'h0000_0000;
      end
    end
  end

  // Stop controls only reach the oscillators when that clock is idle
  always_comb
  begin
    int_gate_next = int_stop_reg && (main_act_reg || cpu_act_reg);
    hs_gate_next = hs_stop_reg && (!main_act_reg || cpu_act_reg);
    sub_gate_next = sub_en_reg || cpu_act_reg;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_sel_reg <= CCSC_DIV_RST;
      cpu_sel_reg <= CCSC_CPU_SEL_RST;
      main_sel_reg <= CCSC_MAIN_SEL_RST;
      hs_en_reg <= CCSC_HS_EN_RST;
      hs_en_locked_reg <= 1'b0;
      hs_stop_reg <= CCSC_HS_STOP_RST;
      int_stop_reg <= CCSC_INT_STOP_RST;
      sub_en_reg <= CCSC_SUB_EN_RST;
      int_freq_reg <= CCSC_INT_FREQ_KHZ_RST;
      hs_freq_reg <= CCSC_HS_FREQ_KHZ_RST;
      sub_freq_reg <= CCSC_SUB_FREQ_HZ_RST;
      div_act_reg <= CCSC_DIV_RST;
      cpu_act_reg <= CCSC_CPU_SEL_RST;
      main_act_reg <= CCSC_MAIN_SEL_RST;
      pcc_acc_reg <= 32'h0000_0000;
      mcm_acc_reg <= 32'h0000_0000;
      int_gate_reg <= CCSC_INT_STOP_RST;
      hs_gate_reg <= 1'b0;
      sub_gate_reg <= CCSC_SUB_EN_RST;
    end
    else
    begin
      div_sel_reg <= div_sel_next;
      cpu_sel_reg <= cpu_sel_next;
      main_sel_reg <= main_sel_next;
      hs_en_reg <= hs_en_next;
      hs_en_locked_reg <= hs_en_locked_next;
      hs_stop_reg <= hs_stop_next;
      int_stop_reg <= int_stop_next;
      sub_en_reg <= sub_en_next;
      int_freq_reg <= int_freq_next;
      hs_freq_reg <= hs_freq_next;
      sub_freq_reg <= sub_freq_next;
      div_act_reg <= div_act_next;
      cpu_act_reg <= cpu_act_next;
      main_act_reg <= main_act_next;
      pcc_acc_reg <= pcc_acc_next;
      mcm_acc_reg <= mcm_acc_next;
      int_gate_reg <= int_gate_next;
      hs_gate_reg <= hs_gate_next;
      sub_gate_reg <= sub_gate_next;
    end
  end

  // Clock selection outputs follow the applied state
  assign main_divider_out = div_act_reg;
  assign cpu_on_subsystem = cpu_act_reg;
  assign main_on_high_speed = main_act_reg;
  assign internal_osc_stop_out = int_gate_reg;
  assign high_speed_clock_stop_out = hs_gate_reg;
  assign subsystem_osc_enable_out = sub_gate_reg;

endmodule
`default_nettype wire

// ==== hw/ccsc_pkg.sv ====
// Purpose: Constants for the CPU clock switchover control block
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes: Frequencies are held in software-written registers; reset values below
package ccsc_pkg;
  // Register byte offsets
  localparam logic [7:0] CCSC_OFS_PROC_CLK = 8'h00;
  localparam logic [7:0] CCSC_OFS_MAIN_MODE = 8'h04;
  localparam logic [7:0] CCSC_OFS_MAIN_OSC = 8'h08;
  localparam logic [7:0] CCSC_OFS_OSC_CTRL = 8'h0C;
  localparam logic [7:0] CCSC_OFS_FREQ_MAIN = 8'h10;
  localparam logic [7:0] CCSC_OFS_FREQ_SUB = 8'h14;
  localparam logic [7:0] CCSC_OFS_BUSY = 8'h18;
  // Field positions, processor_clock_control
  localparam int CCSC_DIV_LSB = 0;
  localparam int CCSC_CPU_SEL_BIT = 4;
  localparam int CCSC_CPU_STAT_BIT = 5;
  // Field positions, main_clock_mode
  localparam int CCSC_MAIN_SEL_BIT = 0;
  localparam int CCSC_MAIN_STAT_BIT = 1;
  localparam int CCSC_HS_EN_BIT = 2;
  // Field positions, main_osc_control and oscillator control
  localparam int CCSC_HS_STOP_BIT = 7;
  localparam int CCSC_INT_STOP_BIT = 0;
  localparam int CCSC_SUB_EN_BIT = 1;
  // Field positions, busy status
  localparam int CCSC_PCC_BUSY_BIT = 0;
  localparam int CCSC_MCM_BUSY_BIT = 1;
  // Reset values
  localparam logic [2:0] CCSC_DIV_RST = 3'h0;
  localparam logic CCSC_CPU_SEL_RST = 1'b0;
  localparam logic CCSC_MAIN_SEL_RST = 1'b0;
  localparam logic CCSC_HS_EN_RST = 1'b0;
  localparam logic CCSC_HS_STOP_RST = 1'b1;
  localparam logic CCSC_INT_STOP_RST = 1'b0;
  localparam logic CCSC_SUB_EN_RST = 1'b0;
  localparam logic [15:0] CCSC_INT_FREQ_KHZ_RST = 16'h1F40;
  localparam logic [15:0] CCSC_HS_FREQ_KHZ_RST = 16'h2710;
  localparam logic [15:0] CCSC_SUB_FREQ_HZ_RST = 16'h8000;
  // Latency counts in old CPU clocks, and scale factors for the main-to-sub wait
  localparam logic [31:0] CCSC_DIV_CHANGE_BASE = 32'h0000_0010;
  localparam logic [31:0] CCSC_SUB_TO_MAIN_CNT = 32'h0000_0002;
  localparam logic [15:0] CCSC_HZ_PER_KHZ = 16'h03E8;
  localparam int CCSC_SUB_SCALE_SHIFT = 4;
  localparam int CCSC_SUB_STEP_SHIFT = 3;
  // AXI responses
  localparam logic [1:0] CCSC_RESP_OKAY = 2'h0;
  localparam logic [1:0] CCSC_RESP_SLVERR = 2'h2;
endpackage

// ==== test/ccsc_cpu_clock_switchover_control_tb.sv ====
// Purpose: Self-checking bench for the clock switchover block
// Assumes: Tick inputs stand in for the old CPU and main clocks
// Notes: Latencies are worked out from the package reset frequencies
`timescale 1ns/10ps
`default_nettype none
module ccsc_cpu_clock_switchover_control_tb
  import ccsc_pkg::*;
();
  localparam int TIMEOUT_CYC = 20000;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic cpu_clk_tick = 1'b0;
  logic main_clk_tick = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_on_subsystem, main_on_high_speed;
  logic internal_osc_stop_out, high_speed_clock_stop_out, subsystem_osc_enable_out;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [2:0] main_divider_out;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;
  // Clock, 100 ns period
  always #50 aclk = ~aclk;
  ccsc_cpu_clock_switchover_control ccsc_cpu_clock_switchover_control_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .cpu_clk_tick(cpu_clk_tick), .main_clk_tick(main_clk_tick), .main_divider_out(main_divider_out),
    .cpu_on_subsystem(cpu_on_subsystem), .main_on_high_speed(main_on_high_speed),
    .internal_osc_stop_out(internal_osc_stop_out), .high_speed_clock_stop_out(high_speed_clock_stop_out),
    .subsystem_osc_enable_out(subsystem_osc_enable_out));
  task automatic final_report();
    $display("Checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard, well above the longest run
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT_CYC)
    begin
      fails++;
      final_report();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // Ready is raised only after the answer shows, so the hold checks get exercised
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    logic done;
    done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
      begin
        done = 1'b1;
        s_axi_bready <= 1'b0;
        chk("bresp", 32'(resp), 32'(s_axi_bresp));
      end
      else if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] resp);
    logic done;
    done = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready)
      begin
        done = 1'b1;
        s_axi_rready <= 1'b0;
        chk("rdata", exp, s_axi_rdata);
        chk("rresp", 32'(resp), 32'(s_axi_rresp));
      end
      else if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
  endtask
  task automatic ticks(input int n, input logic on_main);
    repeat (n)
    begin
      cpu_clk_tick <= !on_main;
      main_clk_tick <= on_main;
      @(posedge aclk);
      cpu_clk_tick <= 1'b0;
      main_clk_tick <= 1'b0;
      @(posedge aclk);
    end
  endtask
  function automatic logic [31:0] state(input logic on_main);
    return on_main ? 32'(main_on_high_speed) : 32'({cpu_on_subsystem, main_divider_out});
  endfunction
  // One switch: old selection must hold through n-1 ticks and change on tick n
  task automatic step(input logic [7:0] a, input logic [31:0] d, input int n, input logic on_main,
                      input logic [31:0] old_s, input logic [31:0] new_s, input logic [31:0] rd_exp);
    wr(a, d, CCSC_RESP_OKAY);
    rd_chk(CCSC_OFS_BUSY, on_main ? 32'h2 : 32'h1, CCSC_RESP_OKAY);
    ticks(n - 1, on_main);
    chk("old source", old_s, state(on_main));
    ticks(1, on_main);
    chk("new source", new_s, state(on_main));
    rd_chk(a, rd_exp, CCSC_RESP_OKAY);
    rd_chk(CCSC_OFS_BUSY, 32'h0, CCSC_RESP_OKAY);
  endtask
  task automatic test_reset();
    chk("hs stop", 32'h1, 32'(high_speed_clock_stop_out));
    chk("osc outs", 32'h0, 32'({internal_osc_stop_out, subsystem_osc_enable_out}));
    chk("cpu state", 32'h0, state(1'b0));
    rd_chk(CCSC_OFS_PROC_CLK, 32'h0, CCSC_RESP_OKAY);
    rd_chk(CCSC_OFS_MAIN_MODE, 32'h0, CCSC_RESP_OKAY);
    rd_chk(CCSC_OFS_MAIN_OSC, 32'h80, CCSC_RESP_OKAY);
    rd_chk(8'h1C, 32'h0, CCSC_RESP_SLVERR);
    wr(CCSC_OFS_BUSY, 32'h3, CCSC_RESP_SLVERR);
    $display("test_reset done");
  endtask
  task automatic test_divider();
    logic [2:0] nd;
    for (int d = 0; d < 5; d++)
    begin
      nd = 3'((d + 1) % 5);
      step(CCSC_OFS_PROC_CLK, 32'(nd), 16 >> d, 1'b0, 32'(d), 32'(nd), 32'(nd));
    end
    $display("test_divider done");
  endtask
  // Main to sub at divider 0 and divider 4, back with a divider change in the same write
  task automatic test_subsystem();
    longint f2;
    longint sub;
    f2 = 2 * 1000 * longint'(CCSC_INT_FREQ_KHZ_RST);
    for (int d = 0; d < 5; d += 4)
    begin
      sub = longint'(CCSC_SUB_FREQ_HZ_RST) << d;
      step(CCSC_OFS_PROC_CLK, 32'h10 | 32'(d), int'((f2 + sub - 1) / sub), 1'b0, 32'(d), 32'h8 | 32'(d),
           32'h30 | 32'(d));
      if (d == 0)
      begin
        wr(CCSC_OFS_OSC_CTRL, 32'h1, CCSC_RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk("stops on sub", 32'h3, 32'({internal_osc_stop_out, subsystem_osc_enable_out}));
      end
      step(CCSC_OFS_PROC_CLK, 32'(4 - d), 2, 1'b0, 32'h8 | 32'(d), 32'(4 - d), 32'(4 - d));
    end
    repeat (2) @(posedge aclk);
    chk("stops on main", 32'h0, 32'({internal_osc_stop_out, subsystem_osc_enable_out}));
    $display("test_subsystem done");
  endtask
  task automatic test_main();
    int up;
    int dn;
    up = 1 + 2 * int'(CCSC_INT_FREQ_KHZ_RST) / int'(CCSC_HS_FREQ_KHZ_RST);
    dn = 1 + 2 * int'(CCSC_HS_FREQ_KHZ_RST) / int'(CCSC_INT_FREQ_KHZ_RST);
    wr(CCSC_OFS_MAIN_MODE, 32'h4, CCSC_RESP_OKAY);
    step(CCSC_OFS_MAIN_MODE, 32'h5, up, 1'b1, 32'h0, 32'h1, 32'h7);
    repeat (2) @(posedge aclk);
    chk("stops on hs", 32'h2, 32'({internal_osc_stop_out, high_speed_clock_stop_out}));
    wr(CCSC_OFS_MAIN_MODE, 32'h1, CCSC_RESP_OKAY);
    rd_chk(CCSC_OFS_MAIN_MODE, 32'h7, CCSC_RESP_OKAY);
    step(CCSC_OFS_MAIN_MODE, 32'h0, dn, 1'b1, 32'h1, 32'h0, 32'h4);
    repeat (2) @(posedge aclk);
    chk("stops on int", 32'h1, 32'({internal_osc_stop_out, high_speed_clock_stop_out}));
    $display("test_main done");
  endtask
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    test_reset();
    test_divider();
    test_subsystem();
    test_main();
    final_report();
  end
endmodule
`default_nettype wire

// ==== test/ccsc_switchover_chk.sv ====
// Purpose: Port-level assertions for the clock switchover block
// Assumes: One aclk domain, synchronous active-low reset
// Notes: Exact latency counts are judged by the bench, not here
`timescale 1ns/10ps
`default_nettype none
module ccsc_switchover_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_arready,
  input wire logic cpu_clk_tick,
  input wire logic main_clk_tick,
  input wire logic [2:0] main_divider_out,
  input wire logic cpu_on_subsystem,
  input wire logic main_on_high_speed,
  input wire logic internal_osc_stop_out,
  input wire logic high_speed_clock_stop_out,
  input wire logic subsystem_osc_enable_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Applied selections move only on an old-clock tick, the divider only while off the subsystem clock; $past(aresetn) skips the reset edge
  property p_cpu_tick; $changed(cpu_on_subsystem) && $past(aresetn) |-> $past(cpu_clk_tick); endproperty
  a_cpu_tick: assert property (p_cpu_tick) else $error("cpu source moved without a tick");
  property p_main_tick; $changed(main_on_high_speed) && $past(aresetn) |-> $past(main_clk_tick); endproperty
  a_main_tick: assert property (p_main_tick) else $error("main source moved without a tick");
  property p_div_tick;
    $changed(main_divider_out) && $past(aresetn) && !$past(cpu_on_subsystem) |-> $past(cpu_clk_tick);
  endproperty
  a_div_tick: assert property (p_div_tick) else $error("divider moved without a tick");
  // Stop controls reach the pins only while the source is unused
  property p_int_gate; internal_osc_stop_out |-> $past(main_on_high_speed || cpu_on_subsystem); endproperty
  a_int_gate: assert property (p_int_gate) else $error("internal osc stopped while in use");
  property p_hs_gate; high_speed_clock_stop_out |-> $past(!main_on_high_speed || cpu_on_subsystem); endproperty
  a_hs_gate: assert property (p_hs_gate) else $error("high-speed clock stopped while in use");
  property p_sub_gate; $past(cpu_on_subsystem) && $past(aresetn) |-> subsystem_osc_enable_out; endproperty
  a_sub_gate: assert property (p_sub_gate) else $error("subsystem osc off while in use");
  // Bus answers stand until taken
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  property p_ar_refuse; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_refuse: assert property (p_ar_refuse) else $error("read address taken while data pending");
endmodule
bind ccsc_cpu_clock_switchover_control ccsc_switchover_chk ccsc_switchover_chk_inst (.aclk(aclk), .aresetn(aresetn),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_arready(s_axi_arready), .cpu_clk_tick(cpu_clk_tick),
  .main_clk_tick(main_clk_tick), .main_divider_out(main_divider_out), .cpu_on_subsystem(cpu_on_subsystem),
  .main_on_high_speed(main_on_high_speed), .internal_osc_stop_out(internal_osc_stop_out),
  .high_speed_clock_stop_out(high_speed_clock_stop_out), .subsystem_osc_enable_out(subsystem_osc_enable_out));
`default_nettype wire
